// ==== hw/phybcs_pkg.sv ====
`default_nettype none
package phybcs_pkg;
   // clock and soft reset timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int SRST_TIME_NS = 80;
   localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] SRST_LOAD = 5'(SRST_CYCLES);
   // management frame layout
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [4:0] HDR_LAST = 5'h0B;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] STRAP_DONE = 2'h3;
   // register map, direct space is 5 bits wide
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   // control register fields
   localparam int CTRL_RST_BIT = 15;
   localparam int CTRL_LOOP_BIT = 14;
   localparam int CTRL_PD_BIT = 11;
   localparam int CTRL_ISO_BIT = 10;
   localparam logic [15:0] CTRL_FIXED = 16'h2100;
   // status register fields
   localparam int STAT_RF_BIT = 4;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_JAB_BIT = 1;
   localparam logic [15:0] STAT_FIXED = 16'h0061;
   localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
   // latched status defaults
   localparam logic RF_RESET = 1'b0;
   localparam logic LINK_RESET = 1'b0;
   localparam logic JAB_RESET = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_HDR,
      ST_TA,
      ST_WDATA,
      ST_RDATA
   } phybcs_state_t;

   typedef struct packed {
      logic [1:0] mdc_sync;
      logic [1:0] mdio_sync;
      logic [1:0] pin_sync;
      logic [7:0] strap_sync;
      logic [1:0] strap_cnt;
      logic [4:0] phy_addr;
      logic mdc_prev;
      phybcs_state_t fsm;
      logic [4:0] bit_cnt;
      logic [5:0] ones_cnt;
      logic synced;
      logic [15:0] shift;
      logic is_read;
      logic addr_hit;
      logic [4:0] reg_addr;
      logic [15:0] out_sh;
      logic loopback;
      logic pd_bit;
      logic isolate;
      logic [4:0] srst_cnt;
      logic rf_latch;
      logic link_latch;
      logic jab_latch;
      logic mdio_out;
      logic mdio_oe_n;
      logic [3:0] mac_rxd;
      logic mac_rx_dv;
      logic powerdown;
      logic isolate_o;
      logic link_ok;
      logic soft_reset;
   } phybcs_regs_t;
endpackage
`default_nettype wire

// ==== hw/phybcs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: control bit 15 soft-resets standard registers
// R2: reset bit self-clears when reset ends
// R3: vendor extended registers untouched by reset
// R4: bit 14 loops MAC transmit to receive
// R5: no link indication during MAC loopback
// R6: control bit 13 reads one, read-only
// R7: control 12 and status 3 read zero
// R8: bit 11 powers down, management stays alive
// R9: power down is bit OR pin
// R10: bit 10 isolates MAC data interface
// R11: status bits 15 to 11 read zero
// R12: preamble needed once; status 6 reads one
// R13: status bit 5 reads one, read-only
// R14: remote fault latches high until read
// R15: link status latches low until read
// R16: jabber latches high until read
// R17: status bit 0 reads one
// R18: control bits 9:0 read 0x100
// R19: direct access covers 0x00 to 0x1F
// R20: latched bits hold until read
// R21: read-only writes ignored; reads clear latches
module phybcs_top (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // serial management port pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n_out,
   // straps and power down pin
   input wire logic [3:0] phy_address_in,
   input wire logic interrupt_powerdown_pin_n_in,
   // line side events
   input wire logic link_up_in,
   input wire logic far_fault_in,
   input wire logic jabber_in,
   input wire logic [3:0] line_rxd_in,
   input wire logic line_rx_dv_in,
   // mac data interface
   input wire logic [3:0] mac_txd_in,
   input wire logic mac_tx_en_in,
   output logic [3:0] mac_rxd_out,
   output logic mac_rx_dv_out,
   // mode outputs
   output logic powerdown_out,
   output logic isolate_out,
   output logic link_ok_out,
   output logic soft_reset_out
);
   phybcs_pkg::phybcs_regs_t q;
   phybcs_pkg::phybcs_regs_t d;
   logic mdc_rise;
   logic bit_in;
   logic [11:0] hdr;
   logic [15:0] wr_data;
   logic pd_eff;
   logic link_eff;
   logic op_ok;
   logic [15:0] rd_word;
   logic [15:0] ctrl_view;

   // read value of a direct register, fixed bits folded in
   function automatic logic [15:0] phybcs_read(input logic [4:0] addr, input phybcs_pkg::phybcs_regs_t s);
      logic [15:0] w;
      w = phybcs_pkg::UNMAPPED_WORD;
      if (addr == phybcs_pkg::REG_CTRL) begin
         // R6: speed bit fixed one
         // R18: reserved pattern fixed
         // R7: autoneg enable zero
         w = phybcs_pkg::CTRL_FIXED;
         w[phybcs_pkg::CTRL_RST_BIT] = (s.srst_cnt != 5'h00);
         w[phybcs_pkg::CTRL_LOOP_BIT] = s.loopback;
         w[phybcs_pkg::CTRL_PD_BIT] = s.pd_bit;
         w[phybcs_pkg::CTRL_ISO_BIT] = s.isolate;
      end else if (addr == phybcs_pkg::REG_STAT) begin
         // R11: legacy ability bits zero
         // R13: negotiation complete fixed one
         // R17: extended capability fixed one
         w = phybcs_pkg::STAT_FIXED;
         w[phybcs_pkg::STAT_RF_BIT] = s.rf_latch;
         w[phybcs_pkg::STAT_LINK_BIT] = s.link_latch;
         w[phybcs_pkg::STAT_JAB_BIT] = s.jab_latch;
      end
      return w;
   endfunction

   // sampled pin views, only second sync stages are read
   assign mdc_rise = q.mdc_sync[1] & ~q.mdc_prev;
   assign bit_in = q.mdio_sync[1];
   assign hdr = {q.shift[10:0], bit_in};
   assign wr_data = {q.shift[14:0], bit_in};
   assign op_ok = (hdr[11:10] == phybcs_pkg::OP_READ) || (hdr[11:10] == phybcs_pkg::OP_WRITE);
   assign rd_word = phybcs_read(hdr[4:0], q);
   // R9: pin or register bit powers down
   assign pd_eff = q.pd_bit | ~q.pin_sync[1];
   // R5: loopback and power down suppress link
   assign link_eff = link_up_in & ~q.loopback & ~pd_eff;

   // next state for the whole block
   always_comb begin
      d = q;
      d.mdc_sync = {q.mdc_sync[0], mdc_in};
      d.mdio_sync = {q.mdio_sync[0], mdio_in};
      d.pin_sync = {q.pin_sync[0], interrupt_powerdown_pin_n_in};
      d.strap_sync = {q.strap_sync[3:0], phy_address_in};
      d.mdc_prev = q.mdc_sync[1];
      // strap caught once the sync pair holds real pin data
      if (q.strap_cnt != phybcs_pkg::STRAP_DONE) begin
         d.strap_cnt = q.strap_cnt + 2'h1;
         d.phy_addr = {1'b0, q.strap_sync[7:4]};
      end
      if (mdc_rise) begin
         case (q.fsm)
            phybcs_pkg::ST_IDLE: begin
               // R12: one preamble, then frames may start bare
               if (bit_in) begin
                  if (q.ones_cnt != phybcs_pkg::PREAMBLE_BITS) begin
                     d.ones_cnt = q.ones_cnt + 6'h01;
                  end else begin
                     d.synced = 1'b1;
                  end
               end else begin
                  d.ones_cnt = 6'h00;
                  if (q.synced || q.ones_cnt == phybcs_pkg::PREAMBLE_BITS) begin
                     d.synced = 1'b1;
                     d.fsm = phybcs_pkg::ST_START;
                  end
               end
            end
            phybcs_pkg::ST_START: begin
               d.bit_cnt = 5'h00;
               d.fsm = bit_in ? phybcs_pkg::ST_HDR : phybcs_pkg::ST_IDLE;
            end
            phybcs_pkg::ST_HDR: begin
               d.shift = {q.shift[14:0], bit_in};
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == phybcs_pkg::HDR_LAST) begin
                  d.bit_cnt = 5'h00;
                  d.is_read = (hdr[11:10] == phybcs_pkg::OP_READ);
                  // R19: five address bits reach the direct space only
                  d.addr_hit = (hdr[9:5] == q.phy_addr);
                  d.reg_addr = hdr[4:0];
                  d.out_sh = rd_word;
                  if (!op_ok) begin
                     // R12: bad opcode demands a fresh preamble
                     d.synced = 1'b0;
                     d.fsm = phybcs_pkg::ST_IDLE;
                  end else begin
                     d.fsm = phybcs_pkg::ST_TA;
                  end
                  // R21: the read that returns latches clears them
                  if (op_ok && hdr[11:10] == phybcs_pkg::OP_READ && hdr[9:5] == q.phy_addr &&
                      hdr[4:0] == phybcs_pkg::REG_STAT) begin
                     d.rf_latch = 1'b0;
                     d.jab_latch = 1'b0;
                     d.link_latch = 1'b1;
                  end
               end
            end
            phybcs_pkg::ST_TA: begin
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == 5'h00) begin
                  if (q.is_read && q.addr_hit) begin
                     d.mdio_out = 1'b0;
                     d.mdio_oe_n = 1'b0;
                  end else if (!q.is_read && !bit_in) begin
                     // R12: bad turnaround demands a fresh preamble
                     d.synced = 1'b0;
                     d.fsm = phybcs_pkg::ST_IDLE;
                  end
               end else begin
                  d.bit_cnt = 5'h00;
                  if (q.is_read) begin
                     d.fsm = phybcs_pkg::ST_RDATA;
                     d.mdio_out = q.out_sh[15];
                     d.out_sh = {q.out_sh[14:0], 1'b0};
                  end else if (bit_in) begin
                     d.synced = 1'b0;
                     d.fsm = phybcs_pkg::ST_IDLE;
                  end else begin
                     d.fsm = phybcs_pkg::ST_WDATA;
                  end
               end
            end
            phybcs_pkg::ST_RDATA: begin
               d.bit_cnt = q.bit_cnt + 5'h01;
               d.mdio_out = q.out_sh[15];
               d.out_sh = {q.out_sh[14:0], 1'b0};
               if (q.bit_cnt == phybcs_pkg::DATA_LAST) begin
                  // bus released after the last data bit period
                  d.mdio_oe_n = 1'b1;
                  d.mdio_out = 1'b0;
                  d.fsm = phybcs_pkg::ST_IDLE;
               end
            end
            phybcs_pkg::ST_WDATA: begin
               d.shift = wr_data;
               d.bit_cnt = q.bit_cnt + 5'h01;
               if (q.bit_cnt == phybcs_pkg::DATA_LAST) begin
                  d.fsm = phybcs_pkg::ST_IDLE;
                  // R21: only the writable control bits are stored
                  if (q.addr_hit && q.reg_addr == phybcs_pkg::REG_CTRL && q.srst_cnt == 5'h00) begin
                     if (wr_data[phybcs_pkg::CTRL_RST_BIT]) begin
                        // R1: soft reset starts, defaults restored
                        d.srst_cnt = phybcs_pkg::SRST_LOAD;
                        d.loopback = 1'b0;
                        d.pd_bit = 1'b0;
                        d.isolate = 1'b0;
                     end else begin
                        d.loopback = wr_data[phybcs_pkg::CTRL_LOOP_BIT];
                        d.pd_bit = wr_data[phybcs_pkg::CTRL_PD_BIT];
                        d.isolate = wr_data[phybcs_pkg::CTRL_ISO_BIT];
                     end
                  end
               end
            end
            default: begin
               d.fsm = phybcs_pkg::ST_IDLE;
               d.mdio_oe_n = 1'b1;
            end
         endcase
      end
      // R2: soft reset counts down and clears itself
      // R3: only the standard register set is held at defaults
      if (q.srst_cnt != 5'h00) begin
         d.srst_cnt = q.srst_cnt - 5'h01;
         d.loopback = 1'b0;
         d.pd_bit = 1'b0;
         d.isolate = 1'b0;
         d.rf_latch = phybcs_pkg::RF_RESET;
         d.link_latch = phybcs_pkg::LINK_RESET;
         d.jab_latch = phybcs_pkg::JAB_RESET;
      end
      // R20: events last so a set beats a read clear
      // R14: remote fault latch
      if (far_fault_in) begin
         d.rf_latch = 1'b1;
      end
      // R16: jabber latch
      if (jabber_in) begin
         d.jab_latch = 1'b1;
      end
      // R15: link loss latches low
      if (!link_eff) begin
         d.link_latch = 1'b0;
      end
      // R9: pin low also sets the register bit
      if (!q.pin_sync[1]) begin
         d.pd_bit = 1'b1;
      end
      // R8: power down quiets the data path
      // R10: isolate forces mac outputs idle
      // R4: loopback returns mac transmit data
      if (q.isolate || pd_eff) begin
         d.mac_rxd = 4'h0;
         d.mac_rx_dv = 1'b0;
      end else if (q.loopback) begin
         d.mac_rxd = mac_txd_in;
         d.mac_rx_dv = mac_tx_en_in;
      end else begin
         d.mac_rxd = line_rxd_in;
         d.mac_rx_dv = line_rx_dv_in;
      end
      d.powerdown = pd_eff;
      d.isolate_o = q.isolate;
      d.link_ok = link_eff;
      d.soft_reset = (d.srst_cnt != 5'h00);
   end

   // control word as a read would see it, for the checks below
   assign ctrl_view = phybcs_read(phybcs_pkg::REG_CTRL, q);

   // single state register; mdc, mdio and power down pin syncs reset to idle-high levels, strap sync to zero
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q <= '0;
         q.mdio_oe_n <= 1'b1;
         q.pin_sync <= 2'h3;
         q.mdc_sync <= 2'h3;
         q.mdio_sync <= 2'h3;
         q.mdc_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign mdio_out = q.mdio_out;
   assign mdio_oe_n_out = q.mdio_oe_n;
   assign mac_rxd_out = q.mac_rxd;
   assign mac_rx_dv_out = q.mac_rx_dv;
   assign powerdown_out = q.powerdown;
   assign isolate_out = q.isolate_o;
   assign link_ok_out = q.link_ok;
   assign soft_reset_out = q.soft_reset;

   // checks on the block's own behaviour
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_rst_start;
      $rose(q.soft_reset);
   endsequence
   sequence s_rst_end;
      ##15 q.soft_reset ##1 !q.soft_reset;
   endsequence
   property p_soft_reset;
      s_rst_start |-> !q.loopback && !q.isolate ##0 s_rst_end;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not end in time"); // R1
   property p_srst_self_clear;
      $fell(q.soft_reset) |-> q.srst_cnt == 5'h00 && ctrl_view[phybcs_pkg::CTRL_RST_BIT] == 1'b0;
   endproperty
   a_srst_self_clear: assert property (p_srst_self_clear) else $error("reset bit still set"); // R2
   property p_loopback;
      q.loopback && !q.isolate && !pd_eff |=> mac_rxd_out == $past(mac_txd_in) && mac_rx_dv_out == $past(mac_tx_en_in);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback data mismatch"); // R4
   property p_no_link_loop;
      q.loopback |=> !link_ok_out;
   endproperty
   a_no_link_loop: assert property (p_no_link_loop) else $error("link shown in loopback"); // R5
   property p_pin_pd;
      !q.pin_sync[1] |=> q.pd_bit && powerdown_out;
   endproperty
   a_pin_pd: assert property (p_pin_pd) else $error("pin did not power down"); // R9
   property p_isolate;
      q.isolate |=> mac_rxd_out == 4'h0 && !mac_rx_dv_out;
   endproperty
   a_isolate: assert property (p_isolate) else $error("isolated port drove data"); // R10
   property p_rf_latch;
      far_fault_in |=> q.rf_latch;
   endproperty
   a_rf_latch: assert property (p_rf_latch) else $error("remote fault not latched"); // R14
   property p_link_latch;
      !link_eff && q.srst_cnt == 5'h00 |=> !q.link_latch;
   endproperty
   a_link_latch: assert property (p_link_latch) else $error("link loss not latched"); // R15
   property p_jab_hold;
      q.jab_latch && !(mdc_rise && q.fsm == phybcs_pkg::ST_HDR) && q.srst_cnt == 5'h00 |=> q.jab_latch;
   endproperty
   a_jab_hold: assert property (p_jab_hold) else $error("jabber latch dropped unread"); // R16
   property p_bad_op;
      mdc_rise && q.fsm == phybcs_pkg::ST_HDR && q.bit_cnt == phybcs_pkg::HDR_LAST && !op_ok |=> !q.synced;
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("bad opcode kept sync"); // R12
   property p_ta_zero;
      $fell(q.mdio_oe_n) |-> !q.mdio_out && q.fsm == phybcs_pkg::ST_TA;
   endproperty
   a_ta_zero: assert property (p_ta_zero) else $error("turnaround not driven low"); // R12
endmodule
`default_nettype wire

// ==== sim/phybcs_mgmt_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// station manager model, drives frames on the management pins
module phybcs_mgmt_model (
   // clock and pacing
   input wire logic clk_in,
   input wire logic [3:0] half_in,
   // management pins
   input wire logic line_in,
   output logic mdc_out,
   output logic drive_out,
   output logic data_out
);
   // clock parks high between frames, line released
   initial begin
      mdc_out = 1'b1;
      drive_out = 1'b0;
      data_out = 1'b1;
   end

   // one bit: change while low, sample just before the rise
   task automatic bit_slot(input logic en, input logic b, output logic s);
      @(posedge clk_in);
      #1;
      mdc_out = 1'b0;
      drive_out = en;
      data_out = b;
      repeat (half_in) @(posedge clk_in);
      #1;
      s = line_in;
      mdc_out = 1'b1;
      repeat (half_in) @(posedge clk_in);
   endtask

   // whole frame, msb first, two released idle bits after it
   task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic [17:0] wbits;
      logic s;
      hdr = {2'b01, op, pa, ra};
      wbits = {2'b10, wd};
      rd = 16'h0000;
      if (pre) repeat (32) bit_slot(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_slot(1'b1, hdr[i], s);
      if (op == phybcs_pkg::OP_READ) begin
         for (int i = 17; i >= 0; i--) begin
            bit_slot(1'b0, 1'b1, s);
            if (i < 16) rd[i] = s;
         end
      end else begin
         for (int i = 17; i >= 0; i--) bit_slot(1'b1, wbits[i], s);
      end
      repeat (2) bit_slot(1'b0, 1'b1, s);
   endtask

   // write header, then a released line: turnaround reads as two ones
   task automatic bad_turn(input logic [4:0] pa, input logic [4:0] ra);
      logic [13:0] hdr;
      logic s;
      hdr = {2'b01, phybcs_pkg::OP_WRITE, pa, ra};
      for (int i = 13; i >= 0; i--) bit_slot(1'b1, hdr[i], s);
      repeat (20) bit_slot(1'b0, 1'b1, s);
   endtask
endmodule
`default_nettype wire

// ==== sim/phybcs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module phybcs_tb_top;
   logic clk_in, nrst_in, mdc, mdio_line, mgr_drv, mgr_dat, mdio_o, mdio_oe_n, pd_pin_n, link_up;
   logic far_fault, jabber, line_dv, mac_tx_en, mac_dv, pd, iso, link_ok, srst, loop_m, pd_m, iso_m;
   logic [3:0] phy_strap, half, line_rxd, mac_txd, mac_rxd;
   logic [4:0] phy, srst_run;
   logic [15:0] rd, w;
   integer seed, failures, checks_done;

   // pull-up on the shared data line when nobody drives
   assign mdio_line = !mdio_oe_n ? mdio_o : (mgr_drv ? mgr_dat : 1'b1);

   phybcs_mgmt_model u_mgr (.clk_in(clk_in), .half_in(half), .line_in(mdio_line), .mdc_out(mdc),
      .drive_out(mgr_drv), .data_out(mgr_dat));

   phybcs_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .mdc_in(mdc), .mdio_in(mdio_line),
      .mdio_out(mdio_o), .mdio_oe_n_out(mdio_oe_n), .phy_address_in(phy_strap),
      .interrupt_powerdown_pin_n_in(pd_pin_n), .link_up_in(link_up), .far_fault_in(far_fault),
      .jabber_in(jabber), .line_rxd_in(line_rxd), .line_rx_dv_in(line_dv), .mac_txd_in(mac_txd),
      .mac_tx_en_in(mac_tx_en), .mac_rxd_out(mac_rxd), .mac_rx_dv_out(mac_dv), .powerdown_out(pd),
      .isolate_out(iso), .link_ok_out(link_ok), .soft_reset_out(srst));

   // 200 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // length of the soft reset pulse
   always @(posedge clk_in) begin
      if (srst === 1'b1) srst_run <= srst_run + 5'h01;
   end

   function automatic logic [15:0] exp_ctrl(input logic lp, input logic pb, input logic ib);
      return phybcs_pkg::CTRL_FIXED | {1'b0, lp, 2'b00, pb, ib, 10'h000};
   endfunction

   function automatic logic [15:0] exp_stat(input logic rf, input logic lk, input logic jb);
      return phybcs_pkg::STAT_FIXED | {11'h000, rf, 1'b0, lk, jb, 1'b0};
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rd_reg(input logic pre, input logic [4:0] ra, output logic [15:0] v);
      u_mgr.frame(pre, phybcs_pkg::OP_READ, phy, ra, 16'h0000, v);
   endtask

   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] v);
      logic [15:0] d;
      u_mgr.frame(1'b0, phybcs_pkg::OP_WRITE, phy, ra, v, d);
   endtask

   // random mac and line data, outputs one clock later
   task automatic chk_mac;
      logic [3:0] e;
      logic ev;
      @(posedge clk_in);
      #1;
      mac_txd = 4'($random(seed));
      mac_tx_en = 1'($random(seed));
      line_rxd = 4'($random(seed));
      line_dv = 1'($random(seed));
      @(posedge clk_in);
      #1;
      e = (iso_m | pd_m) ? 4'h0 : (loop_m ? mac_txd : line_rxd);
      ev = (iso_m | pd_m) ? 1'b0 : (loop_m ? mac_tx_en : line_dv);
      cmp({11'h000, mac_dv, mac_rxd}, {11'h000, ev, e}, "mac data");
      cmp({14'h0000, pd, iso}, {14'h0000, pd_m, iso_m}, "modes");
      cmp({15'h0000, link_ok}, {15'h0000, link_up & !loop_m & !pd_m}, "link ok");
   endtask

   task automatic pulse_events;
      @(posedge clk_in);
      #1;
      link_up = 1'b0;
      far_fault = 1'b1;
      jabber = 1'b1;
      @(posedge clk_in);
      #1;
      link_up = 1'b1;
      far_fault = 1'b0;
      jabber = 1'b0;
   endtask

   task automatic give_verdict;
      $display("checks_done %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // hang guard, well beyond the expected run
   initial begin
      #450000;
      failures++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
   end

   // main sequence
   initial begin
      seed = 32'h8B1B82F7;
      failures = 0;
      checks_done = 0;
      {pd_pin_n, link_up, far_fault, jabber, line_dv, mac_tx_en} = 6'h20;
      {line_rxd, mac_txd, srst_run} = 13'h0000;
      {loop_m, pd_m, iso_m} = 3'h0;
      half = 4'h8;
      phy_strap = 4'($random(seed));
      phy = {1'b0, phy_strap};
      nrst_in = 1'b0;
      repeat (6) @(posedge clk_in);
      #1;
      nrst_in = 1'b1;
      link_up = 1'b1;
      repeat (6) @(posedge clk_in);
      rd_reg(1'b1, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, exp_ctrl(1'b0, 1'b0, 1'b0), "ctrl reset");
      rd_reg(1'b0, phybcs_pkg::REG_STAT, rd);
      cmp(rd, exp_stat(1'b0, 1'b0, 1'b0), "stat reset");
      // mode writes, all ones but bit 15 first, zero last, slow clocks among them
      for (int k = 0; k < 6; k++) begin
         w = (k == 0) ? 16'h7FFF : ((k == 5) ? 16'h0000 : (16'($random(seed)) & 16'h7FFF));
         half = 4'h8 + 4'($random(seed) & 3);
         wr_reg(phybcs_pkg::REG_CTRL, w);
         {loop_m, pd_m, iso_m} = {w[14], w[11], w[10]};
         rd_reg(1'b0, phybcs_pkg::REG_CTRL, rd);
         cmp(rd, exp_ctrl(loop_m, pd_m, iso_m), "ctrl write");
         repeat (3) chk_mac();
      end
      rd_reg(1'b0, phybcs_pkg::REG_STAT, rd);
      rd_reg(1'b0, phybcs_pkg::REG_STAT, rd);
      cmp(rd, exp_stat(1'b0, 1'b1, 1'b0), "link held");
      pulse_events();
      wr_reg(phybcs_pkg::REG_STAT, 16'h0000);
      rd_reg(1'b0, phybcs_pkg::REG_STAT, rd);
      cmp(rd, exp_stat(1'b1, 1'b0, 1'b1), "latched");
      rd_reg(1'b0, phybcs_pkg::REG_STAT, rd);
      cmp(rd, exp_stat(1'b0, 1'b1, 1'b0), "cleared");
      // pin power down, bit stays set after pin release
      #1;
      pd_pin_n = 1'b0;
      pd_m = 1'b1;
      repeat (4) @(posedge clk_in);
      chk_mac();
      pd_pin_n = 1'b1;
      rd_reg(1'b0, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, exp_ctrl(1'b0, 1'b1, 1'b0), "pin sets bit");
      chk_mac();
      wr_reg(phybcs_pkg::REG_CTRL, 16'h0000);
      pd_m = 1'b0;
      chk_mac();
      // foreign address and unmapped register
      u_mgr.frame(1'b0, phybcs_pkg::OP_WRITE, phy ^ 5'h01, phybcs_pkg::REG_CTRL, 16'h4000, rd);
      u_mgr.frame(1'b0, phybcs_pkg::OP_READ, phy ^ 5'h01, phybcs_pkg::REG_CTRL, 16'h0000, rd);
      cmp(rd, 16'hFFFF, "no drive");
      wr_reg(5'h1F, 16'hFFFF);
      rd_reg(1'b0, 5'h1F, rd);
      cmp(rd, phybcs_pkg::UNMAPPED_WORD, "unmapped");
      rd_reg(1'b0, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, exp_ctrl(1'b0, 1'b0, 1'b0), "ctrl kept");
      // bad opcode loses sync until a new preamble
      u_mgr.frame(1'b0, 2'h0, phy, phybcs_pkg::REG_CTRL, 16'h4000, rd);
      rd_reg(1'b0, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, 16'hFFFF, "sync lost");
      rd_reg(1'b1, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, exp_ctrl(1'b0, 1'b0, 1'b0), "resynced");
      // broken write turnaround also drops sync, data never lands
      u_mgr.bad_turn(phy, phybcs_pkg::REG_CTRL);
      rd_reg(1'b0, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, 16'hFFFF, "turnaround sync lost");
      rd_reg(1'b1, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, exp_ctrl(1'b0, 1'b0, 1'b0), "turnaround resynced");
      // soft reset with loopback and a latched event pending
      wr_reg(phybcs_pkg::REG_CTRL, 16'h4000);
      pulse_events();
      srst_run = 5'h00;
      wr_reg(phybcs_pkg::REG_CTRL, 16'hC000);
      cmp({11'h000, srst_run}, {11'h000, phybcs_pkg::SRST_LOAD}, "reset length");
      chk_mac();
      rd_reg(1'b0, phybcs_pkg::REG_CTRL, rd);
      cmp(rd, exp_ctrl(1'b0, 1'b0, 1'b0), "self clear");
      rd_reg(1'b0, phybcs_pkg::REG_STAT, rd);
      cmp(rd, exp_stat(1'b0, 1'b0, 1'b0), "stat defaults");
      give_verdict();
   end
endmodule
`default_nettype wire
